// ### hw/priority_interrupt_gate.sv
// Programmable priority gate between interrupt sources and the core
`timescale 1ns/10ps
module priority_interrupt_gate (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [priority_gate_pkg::ADDR_W-1:0] paddr,
  input wire logic [priority_gate_pkg::DATA_W-1:0] pwdata,
  output logic [priority_gate_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources
  input wire logic [priority_gate_pkg::NSRC-1:0] srcRequest,
  // Core side
  input wire logic vectorFetch,
  input wire priority_gate_pkg::vecnum_t vectorNum,
  input wire logic deepStop,
  output logic [priority_gate_pkg::NSRC-1:0] coreRequest,
  // Event interrupt
  output logic irq
);
  import priority_gate_pkg::*;

  logic enable_q;
  level_t mask_q;
  levels_t levels_q;
  logic [NEV-1:0] irqStat_q;
  logic [NEV-1:0] irqStat_d;
  logic [NEV-1:0] irqMask_q;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] rdData;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic fullPrev_q;
  logic [NSRC-1:0] coreRequest_q;
  logic [STACKD*LVLW-1:0] stackEntries;
  logic [CNT_W-1:0] stackCount;
  logic stackFull;
  logic stackEmpty;
  logic apbSetup;
  logic wrTake;
  logic ctrlWrite;
  logic pullReq;
  logic doPull;
  logic lvlHit;
  logic [ADDR_W-1:0] lvlOff;
  logic [LVLIDX_W-1:0] lvlIdx;
  logic mapped;
  level_t fetchLevel;
  level_t effMask;
  logic [NEV-1:0] events;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign coreRequest = coreRequest_q;

  // Address decode
  assign apbSetup = psel && !penable;
  assign wrTake = psel && penable && pready_q && pwrite;
  assign lvlOff = paddr - OFF_LEVEL0;
  assign lvlIdx = lvlOff[WORD_LSB +: LVLIDX_W];
  assign lvlHit = (paddr >= OFF_LEVEL0) && (paddr <= OFF_LEVEL_LAST)
    && (paddr[WORD_LSB-1:0] == '0);
  assign mapped = lvlHit || paddr == OFF_CTRL || paddr == OFF_STACK
    || paddr == OFF_IRQSTAT || paddr == OFF_IRQMASK;
  assign ctrlWrite = wrTake && paddr == OFF_CTRL;
  assign pullReq = ctrlWrite && pwdata[CTRL_PULL_BIT];
  // A fetch in the same cycle takes the stack; the pull is dropped
  assign doPull = pullReq && !vectorFetch;

  assign fetchLevel = levelOf(levels_q, vectorNum);
  assign effMask = deepStop ? MASK_DEEPSTOP : mask_q;

  // Events: full reached, push while full, pull while empty
  always_comb begin
    events = '0;
    events[EV_FULL] = stackFull && !fullPrev_q;
    events[EV_OVER] = vectorFetch && stackFull;
    events[EV_UNDER] = doPull && stackEmpty;
  end

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    irqStat_d = irqStat_q;
    if (wrTake && paddr == OFF_IRQSTAT) begin
      irqStat_d = irqStat_d & ~pwdata[NEV-1:0];
    end
    irqStat_d = irqStat_d | events;
  end

  // Read mux
  always_comb begin
    rdData = '0;
    if (paddr == OFF_CTRL) begin
      rdData[CTRL_EN_BIT] = enable_q;
      rdData[CTRL_MASK_LSB +: LVLW] = mask_q;
      rdData[CTRL_FULL_BIT] = stackFull;
      rdData[CTRL_EMPTY_BIT] = stackEmpty;
    end else if (lvlHit) begin
      rdData[LVLREG_W-1:0] = levels_q[lvlIdx*LVLREG_W +: LVLREG_W];
    end else if (paddr == OFF_STACK) begin
      rdData[STACKD*LVLW-1:0] = stackEntries;
      rdData[STK_CNT_LSB +: CNT_W] = stackCount;
    end else if (paddr == OFF_IRQSTAT) begin
      rdData[NEV-1:0] = irqStat_q;
    end else if (paddr == OFF_IRQMASK) begin
      rdData[NEV-1:0] = irqMask_q;
    end
  end

  // APB: data and error latched in setup, pready in the access cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clkEn) begin
      pready_q <= apbSetup;
      if (apbSetup) begin
        prdata_q <= pwrite ? '0 : rdData;
        pslverr_q <= !mapped;
      end
    end
  end

  // Handshake steps as this slave sees them
  sequence apbSetupSeq;
    clkEn && psel && !penable;
  endsequence
  sequence apbAccessSeq;
    clkEn && psel && penable;
  endsequence
  sequence apbTransferSeq;
    apbSetupSeq ##1 apbAccessSeq;
  endsequence

  ready_in_access_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    apbTransferSeq |-> pready_q)
    else $error("no ready in the access cycle");
  ready_one_cycle_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && penable && pready_q |=> !pready_q)
    else $error("ready stood longer than one cycle");
  idle_no_ready_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && !apbSetup |=> !pready_q)
    else $error("ready without a setup cycle");
  read_capture_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && apbSetup && !pwrite |=> prdata_q == $past(rdData))
    else $error("read data not captured in setup");
  write_zero_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && apbSetup && pwrite |=> prdata_q == '0)
    else $error("write returned nonzero read data");
  unmapped_err_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && apbSetup && !mapped |=> pslverr_q)
    else $error("unmapped address gave no error");
  mapped_ok_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && apbSetup && mapped |=> !pslverr_q)
    else $error("mapped address gave an error");

  // Gate enable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= 1'b0;
    end else if (clkEn && ctrlWrite) begin
      enable_q <= pwdata[CTRL_EN_BIT];
    end
  end

  enable_write_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && ctrlWrite |=> enable_q == $past(pwdata[CTRL_EN_BIT]))
    else $error("gate enable write lost");

  // Current mask: fetch, then pull, then software write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= MASK_RST;
    end else if (clkEn) begin
      if (vectorFetch) begin
        mask_q <= fetchLevel;
      end else if (doPull) begin
        mask_q <= stackEntries[LVLW-1:0];
      end else if (ctrlWrite) begin
        mask_q <= pwdata[CTRL_MASK_LSB +: LVLW];
      end
    end
  end

  mask_hold_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && !vectorFetch && !ctrlWrite |=> $stable(mask_q))
    else $error("mask moved without fetch or write");
  pull_drop_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && pullReq && vectorFetch |=> mask_q == $past(fetchLevel))
    else $error("pull taken over a fetch");
  fetch_count_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && vectorFetch && !stackFull |=> stackCount == $past(stackCount) + CNT_W'(1))
    else $error("fetch did not grow the stack");

  // Source levels
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      levels_q <= '0;
    end else if (clkEn && wrTake && lvlHit) begin
      levels_q[lvlIdx*LVLREG_W +: LVLREG_W] <= pwdata[LVLREG_W-1:0];
    end
  end

  level_first_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && wrTake && paddr == OFF_LEVEL0
    |=> levels_q[LVLREG_W-1:0] == $past(pwdata[LVLREG_W-1:0]))
    else $error("first level register misplaced");
  level_last_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && wrTake && paddr == OFF_LEVEL_LAST
    |=> levels_q[NSRC*LVLW-1 -: LVLREG_W] == $past(pwdata[LVLREG_W-1:0]))
    else $error("last level register misplaced");
  level_hold_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && !(wrTake && lvlHit) |=> $stable(levels_q))
    else $error("levels moved without a write");

  // Event status, mask and interrupt line
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_q <= IRQ_RST;
      irqMask_q <= IRQ_RST;
      irq_q <= 1'b0;
      fullPrev_q <= 1'b0;
    end else if (clkEn) begin
      irqStat_q <= irqStat_d;
      fullPrev_q <= stackFull;
      if (wrTake && paddr == OFF_IRQMASK) begin
        irqMask_q <= pwdata[NEV-1:0];
      end
      irq_q <= |(irqStat_d & irqMask_q);
    end
  end

  full_event_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && stackFull && !fullPrev_q |=> irqStat_q[EV_FULL])
    else $error("full event not recorded");
  over_event_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && vectorFetch && stackFull |=> irqStat_q[EV_OVER])
    else $error("overflow event not recorded");
  under_event_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && doPull && stackEmpty |=> irqStat_q[EV_UNDER])
    else $error("underflow event not recorded");
  stat_clear_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && wrTake && paddr == OFF_IRQSTAT && events == '0
    |=> (irqStat_q & $past(pwdata[NEV-1:0])) == '0)
    else $error("status bits not cleared by write");
  irq_low_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    clkEn && (irqStat_d & irqMask_q) == '0 |=> !irq_q)
    else $error("irq high with no unmasked event");
  irq_mask_write_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    apbTransferSeq ##0 (pwrite && paddr == OFF_IRQMASK)
    |=> irqMask_q == $past(pwdata[NEV-1:0]))
    else $error("event mask write lost");

  mask_pseudo_stack stack (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .push(vectorFetch),
    .pull(doPull),
    .pushValue(mask_q),
    .entries_q(stackEntries),
    .count_q(stackCount),
    .stackFull(stackFull),
    .stackEmpty(stackEmpty)
  );

  request_gate gate (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .gateEnable(enable_q),
    .effMask(effMask),
    .levels(levels_q),
    .srcRequest(srcRequest),
    .coreRequest_q(coreRequest_q)
  );

  sequence fetchSeq;
    clkEn && vectorFetch;
  endsequence

  fetch_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fetchSeq |=> mask_q == $past(fetchLevel))
    else $error("mask not loaded from fetched source level");
  fetch_push_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fetchSeq |=> stackEntries[LVLW-1:0] == $past(mask_q))
    else $error("previous mask not pushed on fetch");
  pull_restore_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && doPull |=> mask_q == $past(stackEntries[LVLW-1:0]))
    else $error("pull did not restore mask");
  deep_stop_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && deepStop && enable_q && srcRequest[0] |=> coreRequest_q[0])
    else $error("deep stop blocked a request");
  mask_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && ctrlWrite && !vectorFetch && !pullReq
    |=> mask_q == $past(pwdata[CTRL_MASK_LSB +: LVLW]))
    else $error("software mask write lost");
  irq_line_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && |(irqStat_d & irqMask_q) |=> irq_q)
    else $error("unmasked event did not raise irq");
  frozen_state_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    !clkEn |=> $stable(mask_q) && $stable(levels_q) && $stable(enable_q)
      && $stable(irqStat_q) && $stable(prdata_q) && $stable(coreRequest_q))
    else $error("state moved while clock enable low");
endmodule

// ### include/priority_gate_pkg.sv
// Constants, types and helpers shared by the priority gate files
package priority_gate_pkg;
  localparam int NSRC = 32;
  localparam int LVLW = 2;
  localparam int STACKD = 4;
  localparam int FIELDS = 4;
  localparam int LVLREG_W = FIELDS * LVLW;
  localparam int NREG = NSRC / FIELDS;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VEC_W = 5;
  localparam int CNT_W = 3;
  localparam int WORD_LSB = 2;
  localparam int LVLIDX_W = 3;
  localparam int NEV = 3;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LEVEL0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_LEVEL_LAST = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_STACK = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_IRQSTAT = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_IRQMASK = 8'h38;
  // Control and status register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PULL_BIT = 1;
  localparam int CTRL_MASK_LSB = 4;
  localparam int CTRL_FULL_BIT = 8;
  localparam int CTRL_EMPTY_BIT = 9;
  // Stack register fields
  localparam int STK_CNT_LSB = 8;
  // Event bits
  localparam int EV_FULL = 0;
  localparam int EV_OVER = 1;
  localparam int EV_UNDER = 2;
  // Reset values and the deep stop mask
  localparam logic [LVLW-1:0] MASK_RST = 2'h0;
  localparam logic [LVLW-1:0] MASK_DEEPSTOP = 2'h0;
  localparam logic [NEV-1:0] IRQ_RST = 3'h0;

  typedef logic [LVLW-1:0] level_t;
  typedef logic [VEC_W-1:0] vecnum_t;
  typedef logic [NSRC*LVLW-1:0] levels_t;

  // Field of source n: register n/4, bits 2*(n%4)
  function automatic level_t levelOf(input levels_t lv, input vecnum_t n);
    return lv[{n, 1'b0} +: LVLW];
  endfunction
endpackage

// ### hw/mask_pseudo_stack.sv
// Four-deep shift register holding earlier priority masks
`timescale 1ns/10ps
module mask_pseudo_stack (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // Push and pull
  input wire logic push,
  input wire logic pull,
  input wire priority_gate_pkg::level_t pushValue,
  // State
  output logic [priority_gate_pkg::STACKD*priority_gate_pkg::LVLW-1:0] entries_q,
  output logic [priority_gate_pkg::CNT_W-1:0] count_q,
  output logic stackFull,
  output logic stackEmpty
);
  import priority_gate_pkg::*;

  assign stackFull = (count_q == CNT_W'(STACKD));
  assign stackEmpty = (count_q == '0);

  // Newest entry at the bottom; a push when full drops the oldest
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      entries_q <= '0;
      count_q <= '0;
    end else if (clkEn) begin
      if (push) begin
        entries_q <= {entries_q[STACKD*LVLW-LVLW-1:0], pushValue};
        if (!stackFull) begin
          count_q <= count_q + CNT_W'(1);
        end
      end else if (pull) begin
        entries_q <= {MASK_RST, entries_q[STACKD*LVLW-1:LVLW]};
        if (!stackEmpty) begin
          count_q <= count_q - CNT_W'(1);
        end
      end
    end
  end

  sequence pushThenPull;
    clkEn && push ##1 clkEn && pull && !push;
  endsequence

  stack_round_trip_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pushThenPull |=> entries_q[LVLW-1:0] == $past(entries_q[LVLW-1:0], 2))
    else $error("pull did not return the value below the push");
  full_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && push && count_q == CNT_W'(STACKD - 1) |=> stackFull)
    else $error("stack not full after fourth push");
  empty_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && pull && !push && count_q == CNT_W'(1) |=> stackEmpty)
    else $error("stack not empty after last pull");
endmodule

// ### hw/request_gate.sv
// Per-source comparison of level against the effective mask
`timescale 1ns/10ps
module request_gate (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // Control
  input wire logic gateEnable,
  input wire priority_gate_pkg::level_t effMask,
  input wire priority_gate_pkg::levels_t levels,
  // Requests
  input wire logic [priority_gate_pkg::NSRC-1:0] srcRequest,
  output logic [priority_gate_pkg::NSRC-1:0] coreRequest_q
);
  import priority_gate_pkg::*;

  // No reordering here; the core arbitrates simultaneous requests
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      coreRequest_q <= '0;
    end else if (clkEn) begin
      for (int i = 0; i < NSRC; i++) begin
        coreRequest_q[i] <= srcRequest[i] && (!gateEnable
          || levelOf(levels, VEC_W'(i)) >= effMask);
      end
    end
  end

  gate_bypass_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && !gateEnable |=> coreRequest_q == $past(srcRequest))
    else $error("disabled gate did not pass requests");
  gate_pass_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && gateEnable && srcRequest[0] && levels[LVLW-1:0] >= effMask
    |=> coreRequest_q[0])
    else $error("request at or above mask not forwarded");
  gate_block_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && gateEnable && levels[LVLW-1:0] < effMask |=> !coreRequest_q[0])
    else $error("request below mask forwarded");
endmodule

// ### sim/core_fetch_model.sv
// Core model: fetches the lowest-numbered forwarded request on demand
`timescale 1ns/10ps
module core_fetch_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Fetch trigger and forwarded requests
  input wire logic take,
  input wire logic [priority_gate_pkg::NSRC-1:0] coreRequest,
  // Vector fetch
  output logic vectorFetch,
  output priority_gate_pkg::vecnum_t vectorNum
);
  import priority_gate_pkg::*;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      vectorFetch <= 1'b0;
      vectorNum <= '0;
    end else begin
      vectorFetch <= 1'b0;
      // Idle number keeps moving so a stale value is never trusted
      vectorNum <= ~vectorNum;
      if (take && |coreRequest) begin
        vectorFetch <= 1'b1;
        // Fixed built-in order, lowest number wins
        for (int i = NSRC - 1; i >= 0; i--) begin
          if (coreRequest[i]) vectorNum <= vecnum_t'(i);
        end
      end
    end
  end
endmodule

// ### sim/priority_interrupt_gate_bench.sv
// Self-checking bench for the priority interrupt gate
`timescale 1ns/10ps
module priority_interrupt_gate_bench;
  import priority_gate_pkg::*;
  logic clk_sys, reset_n, clkEn, psel, penable, pwrite, take, deepStop;
  logic pready, pslverr, vectorFetch, irq, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd, d;
  logic [NSRC-1:0] srcRequest, coreRequest, s;
  vecnum_t vectorNum;
  level_t lv [NSRC];
  int errCount, testsRun, seed;

  priority_interrupt_gate DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .srcRequest(srcRequest), .vectorFetch(vectorFetch),
    .vectorNum(vectorNum), .deepStop(deepStop), .coreRequest(coreRequest),
    .irq(irq));
  core_fetch_model core (.clk_sys(clk_sys), .reset_n(reset_n), .take(take),
    .coreRequest(coreRequest), .vectorFetch(vectorFetch),
    .vectorNum(vectorNum));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errCount++;
      $display("wrong value at %0t: no ready", $time);
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chkWord(rd, exp);
  endtask

  function automatic logic [NSRC-1:0] expGate(input logic [NSRC-1:0] r,
      input logic en, input level_t m);
    for (int i = 0; i < NSRC; i++) expGate[i] = r[i] && (!en || lv[i] >= m);
  endfunction

  task automatic gateChk(input logic en, input level_t m);
    s = $random(seed);
    @(posedge clk_sys);
    srcRequest <= s;
    repeat (2) @(posedge clk_sys);
    chkWord(coreRequest, expGate(s, en, deepStop ? MASK_DEEPSTOP : m));
  endtask

  initial begin
    seed = 79668;
    errCount = 0;
    testsRun = 0;
    {psel, penable, pwrite, take, deepStop} = 5'h0;
    clkEn = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    srcRequest = 32'h0;
    reset_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdChk(OFF_CTRL, 32'h200);
    chkBit(err, 1'b0);
    rdChk(OFF_STACK, 32'h0);
    rdChk(OFF_LEVEL_LAST, 32'h0);
    rdChk(8'h40, 32'h0);
    chkBit(err, 1'b1);
    $display("test reset done");
    for (int k = 0; k < NREG; k++) begin
      d = $random(seed);
      apb(1'b1, OFF_LEVEL0 + 8'(4 * k), d);
      for (int j = 0; j < FIELDS; j++) lv[4 * k + j] = d[2 * j +: 2];
      rdChk(OFF_LEVEL0 + 8'(4 * k), d & 32'hff);
    end
    repeat (4) gateChk(1'b0, 2'h3);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFF_CTRL, 32'(m) << 4 | 32'h1);
      rdChk(OFF_CTRL, 32'(m) << 4 | 32'h201);
      repeat (3) gateChk(1'b1, level_t'(m));
    end
    // Clock enable low must freeze the forwarded requests
    rd = coreRequest;
    clkEn <= 1'b0;
    srcRequest <= ~srcRequest;
    repeat (3) @(posedge clk_sys);
    chkWord(coreRequest, rd);
    clkEn <= 1'b1;
    deepStop <= 1'b1;
    repeat (3) gateChk(1'b1, 2'h3);
    deepStop <= 1'b0;
    $display("test gating done");
    apb(1'b1, OFF_IRQMASK, 32'h7);
    apb(1'b1, OFF_LEVEL0, 32'he4);
    for (int j = 0; j < 4; j++) lv[j] = level_t'(j);
    apb(1'b1, OFF_CTRL, 32'h1);
    // Nested fetches at levels 0, 1, 2, 3 and 3; the fifth overflows the stack
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys);
      srcRequest <= 32'h1 << (k < 3 ? k : 3);
      @(posedge clk_sys);
      take <= 1'b1;
      @(posedge clk_sys);
      take <= 1'b0;
      repeat (2) @(posedge clk_sys);
      d = 32'(k < 3 ? k : 3) << 4 | (k >= 3 ? 32'h101 : 32'h1);
      rdChk(OFF_CTRL, d);
    end
    srcRequest <= 32'h0;
    rdChk(OFF_STACK, 32'h41b);
    rdChk(OFF_IRQSTAT, 32'h3);
    chkBit(irq, 1'b1);
    repeat (3) gateChk(1'b1, 2'h3);
    $display("test fetch done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFF_CTRL, 32'h3);
      d = 32'(3 - k) << 4;
      rdChk(OFF_CTRL, d | (k == 3 ? 32'h201 : 32'h1));
    end
    apb(1'b1, OFF_CTRL, 32'h3);
    rdChk(OFF_IRQSTAT, 32'h7);
    apb(1'b1, OFF_IRQMASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1;
    chkBit(irq, 1'b0);
    apb(1'b1, OFF_IRQMASK, 32'h4);
    repeat (2) @(posedge clk_sys);
    #1;
    chkBit(irq, 1'b1);
    apb(1'b1, OFF_IRQSTAT, 32'h7);
    rdChk(OFF_IRQSTAT, 32'h0);
    chkBit(irq, 1'b0);
    $display("test pull done");
    results();
  end
endmodule
